/* File: core/ims_map.svh */
/*
  register offsets, field positions, reset values of the interrupt mask block.
  assumes inclusion by bare name from core files.
*/
`ifndef IMS_MAP_SVH
`define IMS_MAP_SVH
// ==========================================
// offsets
`define IMS_UNMASK_CMD_OFS 8'h2C
`define IMS_MASK_CMD_OFS   8'h30
`define IMS_MASK_STATE_OFS 8'h34
`define IMS_RAW_STATE_OFS  8'h38
`define IMS_RAW_CLEAR_OFS  8'h3C
// ==========================================
// fields
`define IMS_NSRC          13
`define IMS_BIT_TIMEOUT   12
`define IMS_BIT_GENCALL   11
`define IMS_BIT_START     10
`define IMS_BIT_STOP      9
`define IMS_BIT_ACTIVITY  8
`define IMS_BIT_RXDONE    7
`define IMS_BIT_TXABORT   6
`define IMS_BIT_RDREQ     5
`define IMS_BIT_TXLOW     4
`define IMS_BIT_TXOVER    3
`define IMS_BIT_RXHIGH    2
`define IMS_BIT_RXOVER    1
`define IMS_BIT_RXUNDER   0
`define IMS_MASK_RESET    13'h0000
`define IMS_RAW_RESET     13'h0000
`endif

/* File: core/ims_pkg.sv */
/*
  types of the interrupt mask block.
  assumes ims_map.svh in the include path.
*/
package ims_pkg;
  // ==========================================
  // source vector
  typedef struct packed {
    logic timeout;
    logic generalCall;
    logic startSeen;
    logic stopSeen;
    logic activity;
    logic rxFinished;
    logic txAborted;
    logic readRequest;
    logic txLow;
    logic txOverrun;
    logic rxHigh;
    logic rxOverrun;
    logic rxUnderrun;
  } ims_src_t;
  // ==========================================
  // ahb-lite request
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ims_ahb_req_t;
endpackage

/* File: core/ims_interrupt_mask.sv */
/*
  interrupt mask state and raw state registers of an i2c controller, ahb-lite slave.
  assumes the protocol engine pulses one event bit per source, and a single
  clock with asynchronous active-high reset.
*/
// How it works
// - bit 12 of mask state shows whether the timeout source is unmasked.
// - bit 11 of mask state shows whether the general call source is unmasked.
// - bit 10 of mask state shows whether start detection is unmasked.
// - bit 9 of mask state shows whether stop detection is unmasked.
// - bit 8 of mask state shows whether activity detection is unmasked.
// - bit 7 of mask state shows whether receive done is unmasked.
// - bit 6 of mask state shows whether transmit abort is unmasked.
// - bit 5 of mask state shows whether remote read request is unmasked.
// - bit 4 of mask state shows whether transmit empty is unmasked.
// - bit 3 of mask state shows whether transmit overflow is unmasked.
// - bit 2 of mask state shows whether receive full is unmasked.
// - bit 1 of mask state shows whether receive overflow is unmasked.
// - bit 0 of mask state shows whether receive underflow is unmasked.
// - one means unmasked, zero masked; every mask bit resets to zero.
// - bits 31 to 13 read zero and ignore writes.
// - writing one to the unmask command sets that mask bit; zeros do nothing.
// - writing one to the mask command clears that mask bit; zeros do nothing.
// - general call raw bit sets only on an acknowledged general call address.
`include "ims_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ims_interrupt_mask #(
  parameter int NSRC = `IMS_NSRC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire ims_pkg::ims_ahb_req_t ahbReq,
  input  wire logic [31:0]          hwdata,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire ims_pkg::ims_src_t    srcEvent,
  input  wire logic                 genCallAcked,
  output logic                      irq,
  output ims_pkg::ims_src_t         unmaskedState
);
  import ims_pkg::*;

  // ==========================================
  // address phase capture
  logic       wrPend_q;
  logic       rdPend_q;
  logic [7:0] addr_q;
  logic       take;

  assign take = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q   <= 8'h00;
    end else begin
      wrPend_q <= take && ahbReq.hwrite;
      rdPend_q <= take && !ahbReq.hwrite;
      if (take) begin
        addr_q <= ahbReq.haddr[7:0];
      end
    end
  end

  // ==========================================
  // write decode
  logic [NSRC-1:0] unmaskWr;
  logic [NSRC-1:0] maskWr;
  logic [NSRC-1:0] rawClrWr;

  assign unmaskWr = (wrPend_q && addr_q == `IMS_UNMASK_CMD_OFS) ? hwdata[NSRC-1:0] : '0;
  assign maskWr   = (wrPend_q && addr_q == `IMS_MASK_CMD_OFS) ? hwdata[NSRC-1:0] : '0;
  assign rawClrWr = (wrPend_q && addr_q == `IMS_RAW_CLEAR_OFS) ? hwdata[NSRC-1:0] : '0;

  // ==========================================
  // mask and raw state per source
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] raw_q;
  logic [NSRC-1:0] evt;

  always_comb begin
    evt = srcEvent;
    evt[`IMS_BIT_GENCALL] = srcEvent.generalCall && genCallAcked;
  end

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : gSrc
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          mask_q[i] <= 1'b0;
        end else if (unmaskWr[i]) begin
          mask_q[i] <= 1'b1;
        end else if (maskWr[i]) begin
          mask_q[i] <= 1'b0;
        end
      end
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          raw_q[i] <= 1'b0;
        end else if (evt[i]) begin
          raw_q[i] <= 1'b1;
        end else if (rawClrWr[i]) begin
          raw_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================
  // interrupt and state outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq           <= 1'b0;
      unmaskedState <= '0;
    end else begin
      irq           <= |(raw_q & mask_q);
      unmaskedState <= mask_q;
    end
  end

  // ==========================================
  // read data, registered so it stands in the data phase
  logic [31:0] rdData;

  always_comb begin
    rdData = 32'h0000_0000;
    unique case (ahbReq.haddr[7:0])
      `IMS_MASK_STATE_OFS: rdData[NSRC-1:0] = mask_q;
      `IMS_RAW_STATE_OFS:  rdData[NSRC-1:0] = raw_q;
      default:             rdData = 32'h0000_0000;
    endcase
  end

  // mask and raw state offsets have no write decode at all
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !ahbReq.hwrite) begin
      hrdata <= rdData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: test/ims_far_end.sv */
/* far end event model. needs ims_pkg. */
`timescale 1ns/100ps
`default_nettype none
module ims_far_end (
  input  wire logic          clk,
  output ims_pkg::ims_src_t  srcEvent,
  output logic               genCallAcked
);
  import ims_pkg::*;
  initial srcEvent = '0;
  initial genCallAcked = 1'b0;
  // ==========================
  // one-cycle event pulse
  task fire(input ims_src_t ev, input logic ack);
    @(posedge clk);
    srcEvent <= ev;
    genCallAcked <= ack;
    @(posedge clk);
    srcEvent <= '0;
    genCallAcked <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/ims_mask_checker.sv */
/* port checker of the mask block. bound to ims_interrupt_mask. */
`timescale 1ns/100ps
`default_nettype none
module ims_mask_checker (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire ims_pkg::ims_ahb_req_t ahbReq,
  input wire logic [31:0]           hwdata,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  irq,
  input wire ims_pkg::ims_src_t     unmaskedState
);
  wire logic tk = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1];
  wire logic rd = tk & !ahbReq.hwrite;
  wire logic [7:0] ofs = ahbReq.haddr[7:0];
  wire logic [12:0] wd = hwdata[12:0];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================
  // properties
  sequence s_un; tk && ahbReq.hwrite && ofs == 8'h2C ##1 1'b1; endsequence
  sequence s_mk; tk && ahbReq.hwrite && ofs == 8'h30 ##1 1'b1; endsequence
  property p_ok; hreadyout && !hresp; endproperty
  property p_rsv; rd |=> hrdata[31:13] == 19'h0; endproperty
  property p_rd; rd && ofs == 8'h34 |=> hrdata[12:0] == unmaskedState; endproperty
  property p_set; s_un |=> ##1 (unmaskedState & $past(wd, 2)) == $past(wd, 2); endproperty
  property p_clr; s_mk |=> ##1 (unmaskedState & $past(wd, 2)) == 13'h0; endproperty
  property p_irq; (unmaskedState == 13'h0) [*3] |-> !irq; endproperty
  property p_ro; tk && ahbReq.hwrite && ofs == 8'h34 |=> $stable(unmaskedState) [*3]; endproperty
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_ok: assert property (p_ok) else $error("not ready okay");
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  a_rd: assert property (p_rd) else $error("mask read wrong");
  a_set: assert property (p_set) else $error("unmask lost");
  a_clr: assert property (p_clr) else $error("mask lost");
  a_irq: assert property (p_irq) else $error("irq while masked");
  a_ro: assert property (p_ro) else $error("state write took");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind ims_interrupt_mask ims_mask_checker chk (.clk(clk), .reset(reset), .ahbReq(ahbReq),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
  .unmaskedState(unmaskedState));
`default_nettype wire

/* File: test/test_ims_interrupt_mask.sv */
/* bench of the mask block. needs the design, checker and far end model. */
`timescale 1ns/100ps
`default_nettype none
module test_ims_interrupt_mask;
  import ims_pkg::*;
  logic clk = 1'b0, reset = 1'b1, sel = 1'b0, wr = 1'b0, hreadyout, hresp, irq, genCallAcked;
  logic [7:0] adr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rdv;
  logic [12:0] want;
  ims_src_t srcEvent;
  ims_ahb_req_t ahbReq;
  int miscompares = 0, checks_done = 0;
  assign ahbReq = '{sel, {24'h0, adr}, {sel, 1'b0}, wr, 3'h2, hreadyout};
  always #5 clk = ~clk;
  ims_interrupt_mask uut (.clk(clk), .reset(reset), .ahbReq(ahbReq), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .srcEvent(srcEvent),
    .genCallAcked(genCallAcked), .irq(irq), .unmaskedState());
  ims_far_end fe (.clk(clk), .srcEvent(srcEvent), .genCallAcked(genCallAcked));
  // ==========================
  // tasks
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp_v);
    checks_done++;
    if (got !== exp_v) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp_v);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    sel <= 1'b1;
    wr <= w;
    adr <= a;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hreadyout !== 1'b1 && n < 9);
      if (hreadyout !== 1'b1) begin
        miscompares++;
        final_report;
      end
      sel <= 1'b0;
      hwdata <= d;
    end
    rdv = hrdata;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp_v);
    xfer(1'b0, a, 32'h0);
    check(rdv, exp_v);
  endtask
  // ==========================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(8'h34, 32'h0);
    rd(8'h40, 32'h0);
    want = 13'h0;
    for (int i = 12; i >= 0; i--) begin
      xfer(1'b1, 8'h2C, 32'h1 << i);
      want[i] = 1'b1;
      rd(8'h34, {19'h0, want});
    end
    xfer(1'b1, 8'h30, 32'h40);
    xfer(1'b1, 8'h2C, 32'h0);
    xfer(1'b1, 8'h34, 32'h0);
    rd(8'h34, 32'h1FBF);
    xfer(1'b1, 8'h2C, 32'hFFFF_FFFF);
    rd(8'h34, 32'h1FFF);
    $display("mask tests done");
    fe.fire(13'h0800, 1'b0);
    rd(8'h38, 32'h0);
    fe.fire(13'h0800, 1'b1);
    rd(8'h38, 32'h0800);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, 8'h38, 32'hFFFF_FFFF);
    xfer(1'b1, 8'h30, 32'h0840);
    fe.fire(13'h0040, 1'b0);
    rd(8'h38, 32'h0840);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h3C, 32'h0000_0840);
    rd(8'h38, 32'h0);
    $display("raw tests done");
    final_report;
  end
endmodule
`default_nettype wire
